// File: host_port_pkg.sv
// constants, encodings and carrier types for the host parallel port
package host_port_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [31:0] HOST_PORT_CONTROL_ADDR = 32'h0188_0000;
    localparam logic [31:0] HOST_WRITE_ADDRESS_ADDR = 32'h0188_0004;
    localparam logic [31:0] HOST_READ_ADDRESS_ADDR = 32'h0188_0008;
    localparam logic [31:0] TRANSFER_REQUEST_CONTROL_ADDR = 32'h018a_0000;

    localparam logic [31:0] HOST_PORT_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] HOST_ADDRESS_RESET = 32'h0000_0000;
    localparam logic [31:0] TRANSFER_REQUEST_CONTROL_RESET = 32'h0000_0000;

    // control bit that reads back the write buffer empty flag
    localparam int CTRL_BUF_EMPTY_BIT = 3;
    // control bit that reads back an outstanding host read
    localparam int CTRL_READ_BUSY_BIT = 4;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'hffff_ffe7;
    // priority field of the transfer request control register
    localparam int TRCTL_PRIO_LSB = 0;
    localparam int PRIO_W = 4;

    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
    localparam int WBUF_DEPTH = 4;

    // ********************************************************
    // encodings
    // ********************************************************
    typedef enum logic [1:0] {
        SEL_CONTROL = 2'b00,
        SEL_ADDRESS = 2'b01,
        SEL_DATA_INC = 2'b10,
        SEL_DATA_FIX = 2'b11
    } host_sel_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ_WAIT = 2'b01,
        ST_HOLD = 2'b10,
        ST_WRITE_WAIT = 2'b11
    } phase_e;

    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        host_sel_e sel;
        logic rd;
    } host_select_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } dma_word_s;

    typedef struct packed {
        logic write;
        logic [PRIO_W-1:0] prio;
        logic [31:0] addr;
        logic [31:0] data;
    } dma_cmd_s;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cpu_req_s;

    typedef struct packed {
        phase_e phase;
        logic strobe_q;
        logic as_low_q;
        logic as_seen;
        logic rd_issued;
        host_select_s cur;
        logic [31:0] ctrl;
        logic [31:0] waddr;
        logic [31:0] raddr;
        logic [31:0] trctl;
        logic [31:0] data_win;
        logic [31:0] host_dout;
        logic host_oe;
        logic ready_b;
        logic dma_req;
        dma_cmd_s dma_cmd;
        logic [31:0] cpu_rdata;
        logic cpu_ack;
    } port_state_s;

    localparam port_state_s PORT_STATE_RESET = '0;

endpackage

// File: host_port_wbuf.sv
// small write buffer memory with registered head word
`timescale 1ns/1ps
module host_port_wbuf #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [WIDTH-1:0] push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [WIDTH-1:0] pop_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] next_rptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign push_ready = (count != DEPTH_C);
    assign pop_valid = (count != '0);
    assign push = push_valid & push_ready;
    assign pop = pop_valid & pop_ready;
    assign next_rptr = pop ? ((rptr == LAST) ? '0 : rptr + 1'b1) : rptr;

    // storage, written on push
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr] <= push_data;
        end
    end

    // pointers, count and head register with bypass into an emptying buffer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            pop_data <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
            end
            rptr <= next_rptr;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
            pop_data <= (push && wptr == next_rptr) ? push_data : mem[next_rptr];
        end
    end
endmodule

// File: host_parallel_port.sv
// host parallel port: host pins, cpu register port and dma request side
//
// How it works
// - host reads and writes any location of the processor memory space
// - every host memory access goes out as an enhanced dma request
// - dma addresses are unrestricted, so peripherals and memories are reached
// - control and address registers are read/write from host and cpu
// - the data window is host only and has no cpu address
// - host reaches data window and control through data lines and controls
// - a host address write loads the write and read copies together
// - cpu reads and writes each address copy at its own location
// - strobe is active when chip select low and data strobes differ
// - data read requests dma once buffered writes have drained; not ready until data loaded
// - data write holds ready off while the write buffer is full
`timescale 1ns/1ps
module host_parallel_port
    import host_port_pkg::*;
#(
    parameter int BUF_DEPTH = WBUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic host_chip_select_b,
    input wire logic host_data_strobe_one,
    input wire logic host_data_strobe_two,
    input wire logic host_address_strobe_b,
    input wire host_port_pkg::host_select_s host_select,
    input wire logic [31:0] host_data_in,
    output logic [31:0] host_data_out,
    output logic host_data_oe,
    output logic host_ready_out_b,
    input wire host_port_pkg::cpu_req_s cpu_req,
    output logic [31:0] cpu_rdata,
    output logic cpu_ack,
    output logic dma_req,
    output host_port_pkg::dma_cmd_s dma_cmd,
    input wire logic dma_ack,
    input wire logic [31:0] dma_rdata
);
    import host_port_pkg::*;

    port_state_s s;
    port_state_s next_s;
    logic combined_host_strobe;
    logic strobe_start;
    logic strobe_stop;
    host_select_s sel_now;
    logic [31:0] ctrl_view;
    logic wb_push;
    logic wb_push_ready;
    dma_word_s wb_push_data;
    logic wb_pop_valid;
    logic wb_pop;
    dma_word_s wb_pop_data;

    // ********************************************************
    // host strobe decode
    // ********************************************************
    // strobe is active high here: chip select low and strobes unequal
    assign combined_host_strobe = ~host_chip_select_b &
        (host_data_strobe_one ^ host_data_strobe_two);
    assign strobe_start = combined_host_strobe & ~s.strobe_q;
    assign strobe_stop = ~combined_host_strobe & s.strobe_q;
    // select latched by the address strobe wins over the live pins
    assign sel_now = s.as_seen ? s.cur : host_select;
    assign ctrl_view = (s.ctrl & CTRL_WRITE_MASK)
        | ({31'h0000_0000, ~wb_pop_valid} << CTRL_BUF_EMPTY_BIT)
        | ({31'h0000_0000, s.phase == ST_READ_WAIT} << CTRL_READ_BUSY_BIT);

    // ********************************************************
    // write buffer
    // ********************************************************
    // buffered writes drain before any read is issued, keeping order
    assign wb_pop = wb_pop_valid & ~s.dma_req;

    host_port_wbuf #(
        .WIDTH($bits(dma_word_s)),
        .DEPTH(BUF_DEPTH)
    ) host_port_wbuf_inst (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .push_valid(wb_push),
        .push_ready(wb_push_ready),
        .push_data(wb_push_data),
        .pop_valid(wb_pop_valid),
        .pop_ready(wb_pop),
        .pop_data(wb_pop_data)
    );

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        next_s = s;
        wb_push = 1'b0;
        wb_push_data = '{addr: s.waddr, data: host_data_in};
        next_s.strobe_q = combined_host_strobe;
        next_s.as_low_q = ~host_address_strobe_b;
        next_s.cpu_ack = 1'b0;

        // address strobe falling edge latches select, once per cycle
        if (~host_address_strobe_b && !s.as_low_q && !s.as_seen) begin
            next_s.cur = host_select;
            next_s.as_seen = 1'b1;
        end

        // dma completion; read data lands in the data window
        if (s.dma_req && dma_ack) begin
            next_s.dma_req = 1'b0;
            if (!s.dma_cmd.write) begin
                next_s.data_win = dma_rdata;
            end
        end

        // drain one buffered write per dma request
        if (wb_pop) begin
            next_s.dma_req = 1'b1;
            next_s.dma_cmd = '{write: 1'b1, prio: s.trctl[TRCTL_PRIO_LSB +: PRIO_W],
                addr: wb_pop_data.addr, data: wb_pop_data.data};
        end

        // cpu register port: one cycle access, answered next cycle
        if (cpu_req.sel) begin
            next_s.cpu_ack = 1'b1;
            next_s.cpu_rdata = 32'h0000_0000;
            if (cpu_req.addr == HOST_PORT_CONTROL_ADDR) begin
                next_s.cpu_rdata = ctrl_view;
                if (cpu_req.wr) begin
                    next_s.ctrl = cpu_req.wdata & CTRL_WRITE_MASK;
                end
            end else if (cpu_req.addr == HOST_WRITE_ADDRESS_ADDR) begin
                next_s.cpu_rdata = s.waddr;
                if (cpu_req.wr) begin
                    next_s.waddr = cpu_req.wdata;
                end
            end else if (cpu_req.addr == HOST_READ_ADDRESS_ADDR) begin
                next_s.cpu_rdata = s.raddr;
                if (cpu_req.wr) begin
                    next_s.raddr = cpu_req.wdata;
                end
            end else if (cpu_req.addr == TRANSFER_REQUEST_CONTROL_ADDR) begin
                next_s.cpu_rdata = s.trctl;
                if (cpu_req.wr) begin
                    next_s.trctl = cpu_req.wdata;
                end
            end
        end

        // host cycle sequencer
        case (s.phase)
            ST_IDLE: begin
                if (strobe_start) begin
                    next_s.cur = sel_now;
                    case (sel_now.sel)
                        SEL_CONTROL: begin
                            next_s.host_dout = ctrl_view;
                            next_s.host_oe = sel_now.rd;
                            next_s.ready_b = 1'b0;
                            next_s.phase = ST_HOLD;
                        end
                        SEL_ADDRESS: begin
                            next_s.host_dout = s.raddr;
                            next_s.host_oe = sel_now.rd;
                            next_s.ready_b = 1'b0;
                            next_s.phase = ST_HOLD;
                        end
                        default: begin
                            if (sel_now.rd) begin
                                next_s.ready_b = 1'b1;
                                next_s.phase = ST_READ_WAIT;
                            end else begin
                                next_s.ready_b = ~wb_push_ready;
                                next_s.phase = ST_WRITE_WAIT;
                            end
                        end
                    endcase
                end
            end
            ST_READ_WAIT: begin
                // issue the read once all buffered writes have gone out
                if (!s.rd_issued && !s.dma_req && !wb_pop_valid) begin
                    next_s.dma_req = 1'b1;
                    next_s.rd_issued = 1'b1;
                    next_s.dma_cmd = '{write: 1'b0,
                        prio: s.trctl[TRCTL_PRIO_LSB +: PRIO_W],
                        addr: s.raddr, data: 32'h0000_0000};
                end
                if (s.rd_issued && s.dma_req && dma_ack) begin
                    next_s.host_dout = dma_rdata;
                    next_s.host_oe = 1'b1;
                    next_s.ready_b = 1'b0;
                    next_s.rd_issued = 1'b0;
                    next_s.phase = ST_HOLD;
                    if (s.cur.sel == SEL_DATA_INC) begin
                        next_s.raddr = s.raddr + ADDR_STEP;
                    end
                end
            end
            ST_WRITE_WAIT: begin
                next_s.ready_b = ~wb_push_ready;
                if (strobe_stop && wb_push_ready) begin
                    wb_push = 1'b1;
                    if (s.cur.sel == SEL_DATA_INC) begin
                        next_s.waddr = s.waddr + ADDR_STEP;
                    end
                end
            end
            default: begin
                // host writes take data at the strobe end; host beats cpu
                if (strobe_stop && !s.cur.rd) begin
                    if (s.cur.sel == SEL_CONTROL) begin
                        next_s.ctrl = host_data_in & CTRL_WRITE_MASK;
                    end else begin
                        next_s.waddr = host_data_in;
                        next_s.raddr = host_data_in;
                    end
                end
            end
        endcase

        // end of strobe closes every access
        if (strobe_stop) begin
            next_s.phase = ST_IDLE;
            next_s.host_oe = 1'b0;
            next_s.ready_b = 1'b0;
            next_s.as_seen = 1'b0;
            next_s.rd_issued = 1'b0;
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= PORT_STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign host_data_out = s.host_dout;
    assign host_data_oe = s.host_oe;
    assign host_ready_out_b = s.ready_b;
    assign cpu_rdata = s.cpu_rdata;
    assign cpu_ack = s.cpu_ack;
    assign dma_req = s.dma_req;
    assign dma_cmd = s.dma_cmd;
endmodule

// File: host_parallel_port_properties.sv
// concurrent checks on the host parallel port pins
`timescale 1ns/1ps
module host_parallel_port_properties
    import host_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic host_chip_select_b,
    input wire logic host_data_strobe_one,
    input wire logic host_data_strobe_two,
    input wire logic host_address_strobe_b,
    input wire host_port_pkg::host_select_s host_select,
    input wire logic [31:0] host_data_in,
    input wire logic [31:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic host_ready_out_b,
    input wire host_port_pkg::cpu_req_s cpu_req,
    input wire logic [31:0] cpu_rdata,
    input wire logic cpu_ack,
    input wire logic dma_req,
    input wire host_port_pkg::dma_cmd_s dma_cmd,
    input wire logic dma_ack,
    input wire logic [31:0] dma_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ************************************************
    // strobe and sequences
    // ************************************************
    wire stb = !host_chip_select_b && (host_data_strobe_one ^ host_data_strobe_two);
    wire [31:0] a = cpu_req.addr;
    wire mapped = a == HOST_PORT_CONTROL_ADDR || a == HOST_WRITE_ADDRESS_ADDR
        || a == HOST_READ_ADDRESS_ADDR || a == TRANSFER_REQUEST_CONTROL_ADDR;
    sequence rd_start;
        $rose(stb) && host_select.sel[1] && host_select.rd;
    endsequence
    sequence idle2;
        !stb ##1 !stb;
    endsequence
    sequence rd_done;
        dma_req && dma_ack && !dma_cmd.write;
    endsequence
    // ************************************************
    // assertions
    // ************************************************
    cpu_ack_a: assert property (cpu_req.sel |=> cpu_ack)
        else $error("cpu ack missing");
    no_ack_a: assert property (!cpu_req.sel |=> !cpu_ack)
        else $error("cpu ack without request");
    unmapped_a: assert property (cpu_req.sel && !mapped |=> cpu_rdata == 32'h0)
        else $error("unmapped read not zero");
    dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_cmd))
        else $error("dma request dropped or changed");
    idle_ready_a: assert property (idle2 |-> !host_ready_out_b)
        else $error("ready high without strobe");
    idle_oe_a: assert property (idle2 |-> !host_data_oe)
        else $error("data driven without strobe");
    read_req_a: assert property (rd_start |=> host_ready_out_b ##[0:60]
        (dma_req && !dma_cmd.write)) else $error("read request missing");
    read_data_a: assert property (rd_done |=> host_data_oe && !host_ready_out_b
        && host_data_out == $past(dma_rdata)) else $error("read data not loaded");
endmodule

bind host_parallel_port host_parallel_port_properties host_parallel_port_properties_inst (
    .clk_sys, .rst_b, .host_chip_select_b, .host_data_strobe_one, .host_data_strobe_two,
    .host_address_strobe_b, .host_select, .host_data_in, .host_data_out, .host_data_oe,
    .host_ready_out_b, .cpu_req, .cpu_rdata, .cpu_ack, .dma_req, .dma_cmd, .dma_ack,
    .dma_rdata
);

// File: host_model.sv
// host processor model running strobe cycles on the port pins
`timescale 1ns/1ps
module host_model
    import host_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic host_ready_out_b,
    input wire logic [31:0] host_data_out,
    output logic host_chip_select_b,
    output logic host_data_strobe_one,
    output logic host_data_strobe_two,
    output host_port_pkg::host_select_s host_select,
    output logic [31:0] host_data_in,
    output logic host_address_strobe_b
);
    int n;
    // idle pins
    initial begin
        host_chip_select_b = 1'b1;
        host_data_strobe_one = 1'b0;
        host_data_strobe_two = 1'b0;
        host_select = '0;
        host_data_in = 32'h0;
        host_address_strobe_b = 1'b1;
    end
    // one host cycle, strobe held until ready is seen low; use_as latches select first
    task automatic cycle(input logic cs_b, input logic use_as, input host_select_s s,
            input logic [31:0] w, output logic [31:0] r);
        @(negedge clk_sys);
        host_select = s;
        if (use_as) begin
            host_address_strobe_b = 1'b0;
            @(negedge clk_sys);
            host_address_strobe_b = 1'b1;
            host_select = ~s; // live select now wrong, latched copy must win
        end
        host_chip_select_b = cs_b;
        host_data_in = w;
        host_data_strobe_two = ~host_data_strobe_one;
        @(posedge clk_sys);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (host_ready_out_b !== 1'b0 && n < 400);
        r = host_data_out;
        @(negedge clk_sys);
        host_chip_select_b = 1'b1;
        host_data_strobe_one = host_data_strobe_two; // equal strobes end the cycle
        // data and select stand through the edge that sees the strobe end
        @(negedge clk_sys);
        host_data_in = ~w; // released lines lose the old value
        host_select = ~s;
        @(negedge clk_sys);
    endtask
endmodule

// File: host_parallel_port_tb_top.sv
// self-checking bench for the host parallel port
`timescale 1ns/1ps
module host_parallel_port_tb_top;
    import host_port_pkg::*;
    logic clk_sys, rst_b, host_chip_select_b, host_data_strobe_one, host_data_strobe_two;
    logic host_address_strobe_b;
    logic host_data_oe, host_ready_out_b, cpu_ack, dma_req, stall;
    logic dma_ack = 1'b0;
    logic [31:0] host_data_in, host_data_out, cpu_rdata;
    logic [31:0] dma_rdata = 32'h0;
    logic [3:0] last_prio;
    host_select_s host_select;
    cpu_req_s cpu_req;
    dma_cmd_s dma_cmd;
    logic [63:0] wq[$];
    int fail_count, tests_run, lat, wait_n, cyc;
    host_parallel_port #(.BUF_DEPTH(2)) host_parallel_port_inst (.clk_sys, .rst_b,
        .host_chip_select_b, .host_data_strobe_one, .host_data_strobe_two,
        .host_address_strobe_b, .host_select, .host_data_in, .host_data_out,
        .host_data_oe, .host_ready_out_b, .cpu_req, .cpu_rdata, .cpu_ack, .dma_req,
        .dma_cmd, .dma_ack, .dma_rdata);
    host_model host_model_inst (.clk_sys, .host_ready_out_b, .host_data_out,
        .host_chip_select_b, .host_data_strobe_one, .host_data_strobe_two, .host_select,
        .host_data_in, .host_address_strobe_b);
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // dma side: answers after lat cycles, silent while stalled
    always @(negedge clk_sys) begin
        if (dma_req && !stall && wait_n >= lat) begin
            dma_ack = 1'b1;
            dma_rdata = dma_cmd.addr ^ 32'h5a5a_0000;
            last_prio = dma_cmd.prio;
            if (dma_cmd.write) wq.push_back({dma_cmd.addr, dma_cmd.data});
            wait_n = 0;
        end else begin
            dma_ack = 1'b0;
            dma_rdata = ~dma_rdata;
            if (!dma_req || stall) wait_n = 0;
            else wait_n++;
        end
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cpu_rw(input logic wr, input logic [31:0] a, w, output logic [31:0] r);
        @(negedge clk_sys);
        cpu_req = {1'b1, wr, a, w};
        @(negedge clk_sys);
        cpu_req.sel = 1'b0;
        @(negedge clk_sys);
        r = cpu_rdata;
    endtask
    task automatic hc(input logic cs_b, input host_sel_e s, input logic rd,
            input logic [31:0] w, output logic [31:0] r);
        host_model_inst.cycle(cs_b, 1'b0, {s, rd}, w, r);
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_regs();
        logic [31:0] r;
        cpu_rw(0, HOST_PORT_CONTROL_ADDR, 0, r);
        chk("ctl reset", 32'h8, r);
        cpu_rw(0, TRANSFER_REQUEST_CONTROL_ADDR, 0, r);
        chk("trctl reset", 32'h0, r);
        cpu_rw(1, HOST_WRITE_ADDRESS_ADDR, 32'h100, r);
        cpu_rw(1, HOST_READ_ADDRESS_ADDR, 32'h200, r);
        cpu_rw(0, HOST_WRITE_ADDRESS_ADDR, 0, r);
        chk("waddr", 32'h100, r);
        cpu_rw(0, HOST_READ_ADDRESS_ADDR, 0, r);
        chk("raddr", 32'h200, r);
        cpu_rw(1, HOST_PORT_CONTROL_ADDR, 32'hf0, r);
        hc(0, SEL_CONTROL, 1, 0, r);
        chk("host ctl", 32'he8, r);
        hc(0, SEL_CONTROL, 0, 32'h103, r);
        hc(1, SEL_CONTROL, 0, 32'h0, r);
        cpu_rw(0, HOST_PORT_CONTROL_ADDR, 0, r);
        chk("cpu ctl", 32'h10b, r);
        host_model_inst.cycle(1'b0, 1'b1, {SEL_CONTROL, 1'b1}, 32'h0, r);
        chk("as ctl", 32'h10b, r);
        cpu_rw(1, TRANSFER_REQUEST_CONTROL_ADDR, 32'h9, r);
        cpu_rw(1, 32'h0188_000c, 32'hffff_ffff, r);
        cpu_rw(0, 32'h0188_000c, 0, r);
        chk("unmapped", 32'h0, r);
    endtask
    task automatic t_read();
        logic [31:0] r;
        hc(0, SEL_ADDRESS, 0, 32'h01b4_0010, r);
        cpu_rw(0, HOST_WRITE_ADDRESS_ADDR, 0, r);
        chk("both waddr", 32'h01b4_0010, r);
        lat = 6;
        hc(0, SEL_DATA_INC, 1, 0, r);
        chk("rd slow", 32'h5bee_0010, r);
        lat = 0;
        hc(0, SEL_DATA_INC, 1, 0, r);
        chk("rd fast", 32'h5bee_0014, r);
        chk("prio", 32'h9, {28'h0, last_prio});
        hc(0, SEL_ADDRESS, 1, 0, r);
        chk("host raddr", 32'h01b4_0018, r);
    endtask
    task automatic t_write();
        logic [31:0] r;
        hc(0, SEL_ADDRESS, 0, 32'h8000_0000, r);
        wq.delete();
        stall = 1'b1;
        fork
            for (int i = 0; i < 5; i++) hc(0, SEL_DATA_INC, 0, 32'hd0 + i, r);
            begin
                repeat (60) @(negedge clk_sys);
                chk("full ready", 32'h1, {31'h0, host_ready_out_b});
                stall = 1'b0;
            end
        join
        repeat (20) @(negedge clk_sys);
        chk("writes", 32'h5, wq.size());
        foreach (wq[i]) chk("wr", {32'h8000_0000 + 4 * i, 32'hd0 + i}, wq[i]);
        cpu_rw(0, HOST_WRITE_ADDRESS_ADDR, 0, r);
        chk("waddr inc", 32'h8000_0014, r);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        cpu_req = '0;
        stall = 1'b0;
        lat = 1;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        t_regs();
        t_read();
        t_write();
        wrap_up();
    end
endmodule
